// *** verilog/hmc_pkg.sv ***
`default_nettype none
package hmc_pkg;
  // clock and timing figures
  localparam int CLK_HZ       = 10_000_000;  // 10 MHz
  localparam int SMP_PER_MS   = 330;         // sample start to start
  localparam int SMP_LEN_US   = 5120;        // open-circuit sample
  localparam int CRIT_MS      = 600;         // shutdown grace time
  localparam int EVAL_US      = 10;          // backup check settle
  localparam int PER_CYC      = SMP_PER_MS * (CLK_HZ / 1000);
  localparam int SMP_CYC      = SMP_LEN_US * (CLK_HZ / 1000000);
  localparam int CRIT_CYC     = CRIT_MS * (CLK_HZ / 1000);
  localparam int EVAL_CYC     = EVAL_US * (CLK_HZ / 1000000);
  localparam int CNT_W        = 23;          // holds 6,000,000
  // register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;   // control
  localparam logic [7:0] ADR_STAT = 8'h04;   // mode and status
  localparam logic [7:0] ADR_CFG  = 8'h08;   // decoded pins
  localparam logic [7:0] ADR_THA  = 8'h0C;   // ovch / chrdy
  localparam logic [7:0] ADR_THB  = 8'h10;   // ovdis / hv
  // control fields
  localparam int         CTL_TRACK = 0;      // tracking enable
  localparam int         CTL_BKUP  = 1;      // backup use enable
  localparam logic [1:0] CTL_RST   = 2'h3;   // both on
  // synchroniser bit positions
  localparam int SY_COLD = 0;
  localparam int SY_OVCH = 1;
  localparam int SY_RDY  = 2;
  localparam int SY_OVDS = 3;
  localparam int SY_BKUP = 4;
  localparam int SY_SHI  = 5;
  localparam int SY_SLO  = 6;
  localparam int SY_LEN  = 7;
  localparam int SY_HEN  = 8;
  localparam int SY_BGND = 9;
  localparam int SY_CFG  = 10;  // three bits
  localparam int SY_SEL  = 13;  // two bits
  localparam int SY_W    = 15;
  // tracking ratios in percent
  localparam logic [7:0] RATIO_50 = 8'h32;
  localparam logic [7:0] RATIO_65 = 8'h41;
  localparam logic [7:0] RATIO_80 = 8'h50;
  localparam logic [15:0] LV_FIXED = 16'h0708;  // 1800 mV

  typedef enum logic [2:0] {
    MODE_DEEP, MODE_WAKE, MODE_NORMAL, MODE_OVERV,
    MODE_EVAL, MODE_PRIMARY, MODE_SHUT
  } hmc_mode_t;

  // {ovch, chrdy, ovdis, hv, lv} in mV; all-low gives custom
  function automatic logic [79:0] hmc_thr(input logic [2:0] cfg);
    case (cfg)
      3'h7:    hmc_thr = {16'h1018, 16'h0E56, 16'h0E10, 16'h0CE4, LV_FIXED};
      3'h6:    hmc_thr = {16'h1018, 16'h0FC8, 16'h0E10, 16'h0CE4, LV_FIXED};
      3'h5:    hmc_thr = {16'h1018, 16'h0E56, 16'h0BC2, 16'h09C4, LV_FIXED};
      3'h4:    hmc_thr = {16'h0A8C, 16'h08FC, 16'h0898, 16'h0708, 16'h04B0};
      3'h3:    hmc_thr = {16'h1194, 16'h0E56, 16'h0AF0, 16'h09C4, LV_FIXED};
      3'h2:    hmc_thr = {16'h1194, 16'h0F50, 16'h0E10, 16'h0CE4, LV_FIXED};
      3'h1:    hmc_thr = {16'h0E2E, 16'h0C1E, 16'h0AF0, 16'h09C4, LV_FIXED};
      default: hmc_thr = {64'h0, LV_FIXED};
    endcase
  endfunction : hmc_thr

  // ratio in percent; zero when impedance matching
  function automatic logic [7:0] hmc_ratio(input logic [1:0] sel);
    case (sel)
      2'h0:    hmc_ratio = RATIO_50;
      2'h1:    hmc_ratio = RATIO_65;
      2'h2:    hmc_ratio = RATIO_80;
      default: hmc_ratio = 8'h00;
    endcase
  endfunction : hmc_ratio
endpackage : hmc_pkg
`default_nettype wire

// *** verilog/hmc_mode_ctrl.sv ***
`default_nettype none
// What this block does
// - at overcharge, pulse boost, rails stay available
// - overvoltage: source switch open while boost idle
// - undervoltage: backup quarter above reference picks primary
// - primary: source open, backup on, until ready
// - status bit 1 high throughout primary
// - no backup: shutdown, warn bit 1, rails on
// - shutdown runs 600 ms timer, ready returns normal
// - timer expiry: deep sleep, rails off, disconnect
// - tracking runs in normal, shutdown, wake
// - every 0.33 s sample open circuit 5.12 ms
// - boost on above target, off below target
// - status bit 2 high while sampling
// - selection maps 50, 65, 80 percent, impedance
// - storage config picks one of seven sets
// - all-low config selects external custom thresholds
// - stop boost at overcharge, rails after ready
// - ground divider only during backup check
// - grounded balance pin disables cell balancing
// - ready threshold: normal mode, status bit 0
// - each rail follows its own enable input
module hmc_mode_ctrl #(
  parameter int PER_CYC  = hmc_pkg::PER_CYC,   // sample start spacing
  parameter int SMP_CYC  = hmc_pkg::SMP_CYC,   // sample length
  parameter int CRIT_CYC = hmc_pkg::CRIT_CYC   // shutdown grace
) (
  input  wire  logic        clk_i,                    // 10 MHz clock
  input  wire  logic        rst_i,                    // sync reset
  input  wire  logic        ce_i,                     // clock enable
  input  wire  logic        wb_cyc_i,                 // bus cycle
  input  wire  logic        wb_stb_i,                 // bus strobe
  input  wire  logic        wb_we_i,                  // write
  input  wire  logic [7:0]  wb_adr_i,                 // byte address
  input  wire  logic [3:0]  wb_sel_i,                 // byte lanes
  input  wire  logic [31:0] wb_dat_i,                 // write data
  output logic       [31:0] wb_dat_o,                 // read data
  output logic              wb_ack_o,                 // acknowledge
  input  wire  logic        cold_start_ok_i,          // enough input
  input  wire  logic        batt_at_ovch_i,           // at overcharge
  input  wire  logic        batt_at_chrdy_i,          // at charge-ready
  input  wire  logic        batt_below_ovdis_i,       // overdischarged
  input  wire  logic        backup_quarter_above_i,   // backup good
  input  wire  logic        src_above_target_i,       // above + hyst
  input  wire  logic        src_below_target_i,       // below - hyst
  input  wire  logic        low_rail_enable_i,        // user enable
  input  wire  logic        high_rail_enable_i,       // user enable
  input  wire  logic        balance_grounded_i,       // pin tied low
  input  wire  logic [2:0]  storage_cfg_i,            // config pins
  input  wire  logic [1:0]  tracking_ratio_select_i,  // ratio pins
  output logic       [2:0]  status_o,                 // status pins
  output logic              low_rail_enable_o,        // low rail gate
  output logic              high_rail_enable_o,       // high rail gate
  output logic              boost_enable_o,           // boost running
  output logic              input_source_switch_o,    // 1 = closed
  output logic              backup_connect_switch_o,  // 1 = closed
  output logic              storage_connect_o,        // 1 = closed
  output logic              backup_divider_ground_o,  // drive level
  output logic              backup_divider_ground_oe_o, // drive on
  output logic              target_refresh_o,         // sample done
  output logic              cell_midpoint_balance_o,  // balancer on
  output logic              impedance_match_pin_o,    // impedance mode
  output logic       [7:0]  tracking_ratio_pct_o,     // ratio percent
  output logic              custom_mode_o,            // external set
  output logic       [15:0] ovch_mv_o,                // overcharge
  output logic       [15:0] chrdy_mv_o,               // charge-ready
  output logic       [15:0] ovdis_mv_o,               // overdischarge
  output logic       [15:0] hv_mv_o,                  // high rail
  output logic       [15:0] lv_mv_o                   // low rail
);
  localparam int CW = hmc_pkg::CNT_W;
  localparam int SW = hmc_pkg::SY_W;

  typedef struct packed {
    logic [SW-1:0]     s1;        // first sync stage
    logic [SW-1:0]     s2;        // second sync stage
    hmc_pkg::hmc_mode_t mode;     // power mode
    logic [CW-1:0]     tmr;       // critical / check timer
    logic [CW-1:0]     mcnt;      // sampling counter
    logic              smp;       // sampling in progress
    logic              trk;       // hysteretic boost request
    logic [1:0]        ctrl;      // control register
    logic [2:0]        status;    // status pins
    logic              lo_en;     // low rail gate
    logic              hi_en;     // high rail gate
    logic              boost;     // boost enable
    logic              src_sw;    // source switch
    logic              bk_sw;     // backup switch
    logic              st_con;    // storage connect
    logic              div_oe;    // divider ground drive
    logic              div_lvl;   // divider level, always low
    logic              refresh;   // target refresh pulse
    logic              cell_midpoint_balance;       // balancer enable
    logic              imp;       // impedance mode
    logic [7:0]        ratio;     // ratio percent
    logic              custom;    // custom thresholds
    logic [79:0]       thr;       // threshold set
    logic              ack;       // bus ack
    logic [31:0]       dat;       // bus read data
  } hmc_state_t;

  hmc_state_t r, n;

  // synchronised inputs
  logic cold_s, ovch_s, rdy_s, ovds_s, bkup_s, shi_s, slo_s;
  logic len_s, hen_s, bgnd_s;
  logic [2:0] cfg_s;
  logic [1:0] sel_s;
  logic mppt_on, ready;

  assign cold_s = r.s2[hmc_pkg::SY_COLD];
  assign ovch_s = r.s2[hmc_pkg::SY_OVCH];
  assign rdy_s  = r.s2[hmc_pkg::SY_RDY];
  assign ovds_s = r.s2[hmc_pkg::SY_OVDS];
  assign bkup_s = r.s2[hmc_pkg::SY_BKUP];
  assign shi_s  = r.s2[hmc_pkg::SY_SHI];
  assign slo_s  = r.s2[hmc_pkg::SY_SLO];
  assign len_s  = r.s2[hmc_pkg::SY_LEN];
  assign hen_s  = r.s2[hmc_pkg::SY_HEN];
  assign bgnd_s = r.s2[hmc_pkg::SY_BGND];
  assign cfg_s  = r.s2[hmc_pkg::SY_CFG +: 3];
  assign sel_s  = r.s2[hmc_pkg::SY_SEL +: 2];

  // next-state logic for the whole block
  always_comb
  begin
    n = r;
    // two-stage synchroniser of pins and comparators
    n.s1 = {tracking_ratio_select_i, storage_cfg_i, balance_grounded_i,
            high_rail_enable_i, low_rail_enable_i, src_below_target_i,
            src_above_target_i, backup_quarter_above_i, batt_below_ovdis_i,
            batt_at_chrdy_i, batt_at_ovch_i, cold_start_ok_i};
    n.s2 = r.s1;
    n.tmr = r.tmr + CW'(1);
    // mode sequencing
    case (r.mode)
      hmc_pkg::MODE_DEEP:
      begin
        n.tmr = '0;
        if (cold_s)
          n.mode = hmc_pkg::MODE_WAKE;
      end
      hmc_pkg::MODE_WAKE:
      begin
        if (rdy_s)
          n.mode = hmc_pkg::MODE_NORMAL;
      end
      hmc_pkg::MODE_NORMAL, hmc_pkg::MODE_OVERV:
      begin
        n.tmr = '0;
        if (ovds_s)
          n.mode = r.ctrl[hmc_pkg::CTL_BKUP] ? hmc_pkg::MODE_EVAL
                                             : hmc_pkg::MODE_SHUT;
        else if (ovch_s)
          n.mode = hmc_pkg::MODE_OVERV;
        else if (r.mode == hmc_pkg::MODE_OVERV && !rdy_s)
          n.mode = hmc_pkg::MODE_NORMAL;
      end
      hmc_pkg::MODE_EVAL:
      begin
        // divider grounded, then the comparator is read
        if (r.tmr == CW'(hmc_pkg::EVAL_CYC - 1))
        begin
          n.tmr  = '0;
          n.mode = bkup_s ? hmc_pkg::MODE_PRIMARY
                          : hmc_pkg::MODE_SHUT;
        end
      end
      hmc_pkg::MODE_PRIMARY:
      begin
        n.tmr = '0;
        if (rdy_s)
          n.mode = hmc_pkg::MODE_NORMAL;
      end
      hmc_pkg::MODE_SHUT:
      begin
        if (rdy_s)
          n.mode = hmc_pkg::MODE_NORMAL;
        else if (r.tmr == CW'(CRIT_CYC - 1))
          n.mode = hmc_pkg::MODE_DEEP;
      end
      default:
        n.mode = hmc_pkg::MODE_DEEP;
    endcase
    if (n.mode != r.mode)
      n.tmr = '0;

    // open-circuit sampling timer
    mppt_on = r.ctrl[hmc_pkg::CTL_TRACK] &&
              (n.mode == hmc_pkg::MODE_NORMAL || n.mode == hmc_pkg::MODE_SHUT ||
               n.mode == hmc_pkg::MODE_WAKE);
    n.refresh = 1'b0;
    n.mcnt    = r.mcnt + CW'(1);
    if (!mppt_on)
    begin
      n.smp  = 1'b0;
      n.mcnt = '0;
    end
    else if (r.smp && r.mcnt == CW'(SMP_CYC - 1))
    begin
      n.smp     = 1'b0;
      n.mcnt    = '0;
      n.refresh = 1'b1;
    end
    else if (!r.smp && r.mcnt == CW'(PER_CYC - SMP_CYC - 1))
    begin
      n.smp  = 1'b1;
      n.mcnt = '0;
    end

    // hysteretic boost request outside sampling
    if (n.smp)
      n.trk = 1'b0;
    else if (shi_s)
      n.trk = 1'b1;
    else if (slo_s)
      n.trk = 1'b0;

    // switch and boost control per mode
    n.bk_sw  = (n.mode == hmc_pkg::MODE_PRIMARY);
    n.st_con = (n.mode != hmc_pkg::MODE_DEEP);
    n.div_oe = (n.mode == hmc_pkg::MODE_EVAL);
    n.div_lvl = 1'b0;
    case (n.mode)
      hmc_pkg::MODE_DEEP:
      begin
        n.boost  = 1'b0;
        n.src_sw = 1'b1;
      end
      hmc_pkg::MODE_OVERV:
      begin
        n.boost  = !ovch_s;
        n.src_sw = n.boost;
      end
      hmc_pkg::MODE_PRIMARY:
      begin
        n.boost  = !ovch_s;
        n.src_sw = 1'b0;
      end
      hmc_pkg::MODE_EVAL:
      begin
        n.boost  = 1'b0;
        n.src_sw = 1'b1;
      end
      default:
      begin
        n.boost  = (mppt_on ? n.trk : 1'b1) && !ovch_s;
        n.src_sw = !n.smp;
      end
    endcase

    // status pins and rail gating
    ready = (n.mode == hmc_pkg::MODE_NORMAL || n.mode == hmc_pkg::MODE_OVERV ||
             n.mode == hmc_pkg::MODE_PRIMARY || n.mode == hmc_pkg::MODE_SHUT);
    n.status[0] = ready;
    n.status[1] = (n.mode == hmc_pkg::MODE_PRIMARY) ||
                  (n.mode == hmc_pkg::MODE_SHUT);
    n.status[2] = n.smp;
    n.lo_en = ready && len_s;
    n.hi_en = ready && hen_s;

    // configuration decode
    n.cell_midpoint_balance    = !bgnd_s;
    n.thr    = hmc_pkg::hmc_thr(cfg_s);
    n.custom = (cfg_s == 3'h0);
    n.ratio  = hmc_pkg::hmc_ratio(sel_s);
    n.imp    = (sel_s == 2'h3);

    // classic wishbone slave, one wait state
    n.ack = 1'b0;
    n.dat = 32'h0000_0000;
    if (wb_cyc_i && wb_stb_i && !r.ack)
    begin
      n.ack = 1'b1;
      if (wb_we_i && wb_adr_i == hmc_pkg::ADR_CTRL && wb_sel_i[0])
        n.ctrl = wb_dat_i[1:0];
      case (wb_adr_i)
        hmc_pkg::ADR_CTRL: n.dat = {30'h0, r.ctrl};
        hmc_pkg::ADR_STAT: n.dat = {23'h0, r.boost, r.src_sw, r.mode,
                                    r.trk, r.status};
        hmc_pkg::ADR_CFG:  n.dat = {16'h0, r.ratio, r.cell_midpoint_balance, r.imp,
                                    r.custom, cfg_s, sel_s};
        hmc_pkg::ADR_THA:  n.dat = r.thr[79:48];
        hmc_pkg::ADR_THB:  n.dat = r.thr[47:16];
        default:           n.dat = 32'h0000_0000;
      endcase
    end
  end

  // state register, frozen while ce_i is low; rst_i still loads reset values
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r      <= '0;
      r.mode <= hmc_pkg::MODE_DEEP;
      r.ctrl <= hmc_pkg::CTL_RST;
    end
    else if (ce_i)
      r <= n;
  end

  // outputs straight from the state register
  assign wb_dat_o                   = r.dat;
  assign wb_ack_o                   = r.ack;
  assign status_o                   = r.status;
  assign low_rail_enable_o          = r.lo_en;
  assign high_rail_enable_o         = r.hi_en;
  assign boost_enable_o             = r.boost;
  assign input_source_switch_o      = r.src_sw;
  assign backup_connect_switch_o    = r.bk_sw;
  assign storage_connect_o          = r.st_con;
  assign backup_divider_ground_o    = r.div_lvl;
  assign backup_divider_ground_oe_o = r.div_oe;
  assign target_refresh_o           = r.refresh;
  assign cell_midpoint_balance_o    = r.cell_midpoint_balance;
  assign impedance_match_pin_o      = r.imp;
  assign tracking_ratio_pct_o       = r.ratio;
  assign custom_mode_o              = r.custom;
  assign ovch_mv_o                  = r.thr[79:64];
  assign chrdy_mv_o                 = r.thr[63:48];
  assign ovdis_mv_o                 = r.thr[47:32];
  assign hv_mv_o                    = r.thr[31:16];
  assign lv_mv_o                    = r.thr[15:0];

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ovv_switch_a: assert property ((r.mode == hmc_pkg::MODE_OVERV && !r.boost)
    |-> !r.src_sw) else $error("source switch closed while boost idle");
  eval_pick_a: assert property ((r.mode == hmc_pkg::MODE_EVAL && ce_i &&
    r.tmr == CW'(hmc_pkg::EVAL_CYC - 1) && bkup_s)
    |=> r.mode == hmc_pkg::MODE_PRIMARY) else $error("backup not taken");
  backup_cell_input_switch_a: assert property (r.mode == hmc_pkg::MODE_PRIMARY
    |-> r.bk_sw && !r.src_sw) else $error("primary switches wrong");
  backup_cell_input_status_a: assert property (r.mode == hmc_pkg::MODE_PRIMARY
    |-> status_o[1]) else $error("status bit 1 low in primary");
  shut_warn_a: assert property (r.mode == hmc_pkg::MODE_SHUT
    |-> status_o[1] && status_o[0]) else $error("shutdown warning missing");
  crit_bound_a: assert property (r.mode == hmc_pkg::MODE_SHUT
    |-> r.tmr < CW'(CRIT_CYC)) else $error("critical timer overran");
  crit_expire_a: assert property ((r.mode == hmc_pkg::MODE_SHUT && ce_i &&
    !rdy_s && r.tmr == CW'(CRIT_CYC - 1))
    |=> r.mode == hmc_pkg::MODE_DEEP) else $error("no deep sleep at expiry");
  deep_off_a: assert property (r.mode == hmc_pkg::MODE_DEEP
    |-> !r.lo_en && !r.hi_en && !r.st_con) else $error("deep sleep not off");
  sample_open_a: assert property (status_o[2]
    |-> !r.src_sw && !r.boost) else $error("sampling with source on");
  smp_len_a: assert property (r.smp |-> r.mcnt < CW'(SMP_CYC))
    else $error("sample too long");
  rail_ready_a: assert property ((low_rail_enable_o || high_rail_enable_o)
    |-> status_o[0]) else $error("rail enabled before ready");
  div_ground_a: assert property (backup_divider_ground_oe_o
    |-> r.mode == hmc_pkg::MODE_EVAL) else $error("divider grounded late");
  ack_drop_a: assert property ((wb_ack_o && ce_i) |=> !wb_ack_o)
    else $error("ack held two cycles");
  // mode and sample-end invariants on status pins and rails
  wake_rails_a: assert property (r.mode == hmc_pkg::MODE_WAKE
    |-> !status_o[0] && !low_rail_enable_o) else $error("rails ready in wake");
  normal_ready_a: assert property (r.mode == hmc_pkg::MODE_NORMAL
    |-> status_o[0] && !status_o[1]) else $error("normal mode not ready");
  ovv_rails_a: assert property (r.mode == hmc_pkg::MODE_OVERV
    |-> status_o[0] && !r.bk_sw) else $error("rails gone in overvoltage");
  refresh_end_a: assert property (target_refresh_o
    |-> !status_o[2]) else $error("refresh during sample");
endmodule : hmc_mode_ctrl
`default_nettype wire

// *** tb/hmc_load_model.sv ***
`default_nettype none
// load model: counts warning rises, drives rail enables
module hmc_load_model (
  input  wire logic       clk_i,        // system clock
  input  wire logic       rst_i,        // sync reset
  input  wire logic [2:0] status_i,     // status pins
  input  wire logic       want_low_i,   // load asks low rail
  input  wire logic       want_high_i,  // load asks high rail
  output logic            low_en_o,     // low rail enable
  output logic            high_en_o,    // high rail enable
  output logic [7:0]      irq_cnt_o     // warning rises seen
);
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] irq;  // rise count
    logic       prv;  // last warning level
    logic       lo;   // low enable
    logic       hi;   // high enable
  } hmc_load_st_t;
  hmc_load_st_t st_r, st_nxt;  // state and next
  // rising warning is the power-down interrupt
  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.prv = status_i[1];
    st_nxt.lo  = want_low_i;
    st_nxt.hi  = want_high_i;
    if (status_i[1] && !st_r.prv)
    begin
      st_nxt.irq = st_r.irq + 8'h01;
    end
  end
  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign low_en_o  = st_r.lo;
  assign high_en_o = st_r.hi;
  assign irq_cnt_o = st_r.irq;
endmodule : hmc_load_model
`default_nettype wire

// *** tb/hmc_mode_ctrl_test.sv ***
`default_nettype none
// bench: pin stimulus, bus accesses, load model on status pins
module hmc_mode_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PER  = 400;  // sample spacing
  localparam int SMP  = 50;   // sample length
  localparam int CRIT = 300;  // shutdown grace
  logic        clk_i, rst_i, cyc, stb, we, ack, cold, ovch, rdy, ovds, bkq;  // bus, comparators
  logic        sab, sbl, bgnd, wl, wh, len, hen, boost, srcsw, bksw, stor;   // pins, gates
  logic        divg, divoe, refr, cell_midpoint_balance, imp, cust, ce, lme, hme;  // misc, enables
  logic [7:0]  adr, ratio, irq;                    // address, ratio, warnings
  logic [3:0]  sel;                                // byte lanes
  logic [31:0] wdat, rdat, q;                      // bus data
  logic [2:0]  cfg, status;                        // config, status
  logic [1:0]  tsel;                               // tracking select
  logic [15:0] thov, thrdy, thod;                  // thresholds
  logic [7:0]  rtab [4] = '{8'h32, 8'h41, 8'h50, 8'h00};  // expected ratios
  int          fails = 0, cmp_count = 0, cycles = 0, n;   // counters
  hmc_mode_ctrl #(.PER_CYC(PER), .SMP_CYC(SMP), .CRIT_CYC(CRIT)) i_hmc_mode_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .cold_start_ok_i(cold), .batt_at_ovch_i(ovch), .batt_at_chrdy_i(rdy),
    .batt_below_ovdis_i(ovds), .backup_quarter_above_i(bkq), .src_above_target_i(sab),
    .src_below_target_i(sbl), .low_rail_enable_i(lme), .high_rail_enable_i(hme),
    .balance_grounded_i(bgnd), .storage_cfg_i(cfg), .tracking_ratio_select_i(tsel),
    .status_o(status), .low_rail_enable_o(len), .high_rail_enable_o(hen),
    .boost_enable_o(boost), .input_source_switch_o(srcsw), .backup_connect_switch_o(bksw),
    .storage_connect_o(stor), .backup_divider_ground_o(divg),
    .backup_divider_ground_oe_o(divoe), .target_refresh_o(refr),
    .cell_midpoint_balance_o(cell_midpoint_balance), .impedance_match_pin_o(imp), .tracking_ratio_pct_o(ratio),
    .custom_mode_o(cust), .ovch_mv_o(thov), .chrdy_mv_o(thrdy), .ovdis_mv_o(thod),
    .hv_mv_o(), .lv_mv_o());
  hmc_load_model i_hmc_load_model (.clk_i(clk_i), .rst_i(rst_i), .status_i(status),
    .want_low_i(wl), .want_high_i(wh), .low_en_o(lme), .high_en_o(hme), .irq_cnt_o(irq));
  // clock, 100 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      summarize();
    end
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // let k edges pass, then settle
  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : step
  // one classic cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("wb_ack", 2, k);
  endtask : wb
  // read mode field of status word
  task automatic mode(input logic [2:0] e);
    wb(1'b0, hmc_pkg::ADR_STAT, 32'h0);
    chk("mode", e, q[6:4]);
  endtask : mode
  // verdict
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  // main sequence
  initial
  begin
    {cyc, stb, we, cold, ovch, rdy, ovds, bkq, sab, sbl, wl, wh} = '0;
    {adr, wdat, tsel} = '0;
    sel   = 4'hF;
    ce    = 1'b1;
    cfg   = 3'h7;
    bgnd  = 1'b1;
    rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wl    <= 1'b1;
    wh    <= 1'b1;
    step(4);
    chk("status", 0, status);
    chk("store", 0, stor);
    wb(1'b0, hmc_pkg::ADR_CTRL, 32'h0);
    chk("ctrl", 3, q);
    wb(1'b1, hmc_pkg::ADR_STAT, 32'hFFFF_FFFF);
    mode(3'h0);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 0, q);
    chk("ovch_mv", 16'h1018, thov);
    chk("rdy_mv", 16'h0E56, thrdy);
    chk("ovds_mv", 16'h0E10, thod);
    chk("bal_off", 0, cell_midpoint_balance);
    @(posedge clk_i);
    cfg  <= 3'h0;
    bgnd <= 1'b0;
    step(5);
    chk("custom", 1, cust);
    chk("bal_on", 1, cell_midpoint_balance);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_i);
      tsel <= 2'(i);
      step(5);
      chk("ratio", rtab[i], ratio);
      chk("imp", i == 3, imp);
    end
    @(posedge clk_i);
    cfg  <= 3'h7;
    cold <= 1'b1;
    step(6);
    chk("rails_wake", 0, {status[0], len, hen});
    n = 0;
    while (status[2] !== 1'b1 && n < 500)
    begin
      step(1);
      n++;
    end
    n = 0;
    while (status[2] === 1'b1 && n < 500)
    begin
      chk("smp_gate", 0, {srcsw, boost});
      step(1);
      n++;
    end
    chk("smp_len", SMP, n);
    chk("refresh", 1, refr);
    @(posedge clk_i);
    sab <= 1'b1;
    step(5);
    chk("boost_on", 1, boost);
    @(posedge clk_i);
    sab <= 1'b0;
    sbl <= 1'b1;
    step(5);
    chk("boost_off", 0, boost);
    n = SMP + 12;
    while (status[2] !== 1'b1 && n < 1000)
    begin
      step(1);
      n++;
    end
    chk("smp_per", PER, n);
    @(posedge clk_i);
    rdy <= 1'b1;
    wl  <= 1'b0;
    step(8);
    chk("ready", 1, status[0]);
    chk("rails", 2'b01, {len, hen});
    mode(3'h2);
    @(posedge clk_i);
    wl   <= 1'b1;
    ovch <= 1'b1;
    cold <= 1'b0;
    step(5);
    chk("ovv_gate", 0, {boost, srcsw});
    chk("ovv_rails", 2'b11, {len, hen});
    mode(3'h3);
    @(posedge clk_i);
    ovch <= 1'b0;
    step(5);
    chk("ovv_pulse", 2'b11, {boost, srcsw});
    mode(3'h3);
    @(posedge clk_i);
    rdy  <= 1'b0;
    step(5);
    mode(3'h2);
    @(posedge clk_i);
    ovds <= 1'b1;
    bkq  <= 1'b1;
    step(5);
    chk("div_check", 2'b10, {divoe, divg});
    step(110);
    mode(3'h5);
    chk("backup_cell_input", 4'b1100, {status[1], bksw, srcsw, divoe});
    @(posedge clk_i);
    ovds <= 1'b0;
    step(20);
    chk("backup_cell_input_hold", 1, status[1]);
    @(posedge clk_i);
    rdy <= 1'b1;
    step(5);
    mode(3'h2);
    chk("backup_cell_input_exit", 0, status[1]);
    @(posedge clk_i);
    rdy  <= 1'b0;
    bkq  <= 1'b0;
    ovds <= 1'b1;
    step(110);
    mode(3'h6);
    chk("shut", 3'b111, {status[1], len, hen});
    chk("irq", 2, irq);
    @(posedge clk_i);
    ovds <= 1'b0;
    rdy  <= 1'b1;
    step(5);
    mode(3'h2);
    @(posedge clk_i);
    rdy  <= 1'b0;
    ovds <= 1'b1;
    step(110 + CRIT + 10);
    mode(3'h0);
    chk("deep", 0, {len, hen, stor, status});
    @(posedge clk_i);
    ce   <= 1'b0;
    cold <= 1'b1;
    step(6);
    chk("ce_freeze", 0, stor);
    @(posedge clk_i);
    ce <= 1'b1;
    step(4);
    chk("ce_run", 1, stor);
    mode(3'h1);
    summarize();
  end
endmodule : hmc_mode_ctrl_test
`default_nettype wire
